// ==== logic/jlem_monitor.v ====
// Link error and establishment status monitor for an 8-lane, 2-link receiver
// Assumes per-lane error strobes and status levels from the lane decoders, a
// byte-wide register port from the serial control interface, one clock per octet
// and a half-clock pulse option taken as one high-rate cycle from pclk_half_i.
`timescale 1ns/1ns
`default_nettype none
`include "jlem_consts.vh"

module jlem_monitor #(
  parameter LANES = 8,
  parameter FRAME_OCTETS = 8'h02
) (
  input  wire                   clk_i,
  input  wire                   reset_i,
  input  wire                   pclk_tick_i,
  input  wire                   pclk_half_i,
  input  wire                   frame_tick_i,
  input  wire [LANES-1:0]       disp_err_i,
  input  wire [LANES-1:0]       not_in_table_error_i,
  input  wire [LANES-1:0]       ctrl_err_i,
  input  wire [LANES-1:0]       cgs_ok_i,
  input  wire [LANES-1:0]       fsync_ok_i,
  input  wire [LANES-1:0]       ilas_ok_i,
  input  wire [LANES-1:0]       ilas_done_i,
  input  wire [8*LANES-1:0]     rx_field_sum_i,
  input  wire [8*LANES-1:0]     rx_reg_sum_i,
  input  wire [8*LANES-1:0]     rx_lane_id_i,
  input  wire [8*LANES-1:0]     rx_chksum_i,
  input  wire [1:0]             cfg_mismatch_i,
  input  wire                   reg_wr_i,
  input  wire                   reg_rd_i,
  input  wire [`JLEM_ADDR_W-1:0] reg_addr_i,
  input  wire [7:0]             reg_wdata_i,
  output reg  [7:0]             reg_rdata_o,
  output wire                   link_page_o,
  output reg                    reinit_o,
  output wire                   irq_n_o,
  output reg  [1:0]             sync_request_out_n_o
);

  localparam HALF = LANES / 2;
  localparam ST_IDLE = 3'b001;
  localparam ST_PULSE = 3'b010;
  localparam ST_HOLD = 3'b100;

  reg  [7:0]          page_r, pulse_cfg_r, thr_r, irqen_r, mask_r, limit_r;
  reg  [LANES-1:0]    chk_ok_r;
  reg  [7:0]          cntsel_r;
  wire [LANES-1:0]    chk_now;
  reg  [LANES-1:0]    irq_err_r [0:2];
  reg  [LANES-1:0]    dis_cnt_r [0:2];
  reg  [7:0]          cnt_r [0:3*LANES-1];
  reg  [2:0]          disp_run_r [0:LANES-1];
  reg  [3:0]          irq_st_r;
  reg                 mm_st_r;
  reg  [2:0]          state_r [0:1];
  reg  [7:0]          tmr_r [0:1];
  reg  [LANES-1:0]    cgs_d_r, fs_d_r, il_d_r;

  wire [2:0]          err_any [0:1];
  wire [2:0]          at_lim [0:1];
  wire [1:0]          disp4;
  wire                gate = thr_r[`JLEM_GATE_BIT];
  wire                pg = page_r[`JLEM_PAGE_BIT];
  wire [7:0]          hold_len = `JLEM_RESYNC_FRAMES * FRAME_OCTETS + `JLEM_RESYNC_OCTETS;

  assign link_page_o = pg;

  // Selects the half of a lane vector belonging to the paged link
  function [7:0] page_sel;
    input [LANES-1:0] v;
    input             p;
    begin
      page_sel = p ? {{(8-HALF){1'b0}}, v[LANES-1:HALF]} : {{(8-HALF){1'b0}}, v[HALF-1:0]};
    end
  endfunction

  function wr_hit;
    input [`JLEM_ADDR_W-1:0] a;
    begin
      wr_hit = reg_wr_i && (reg_addr_i == a);
    end
  endfunction

  // Lane index addressed through an error control write on the paged link
  wire [3:0] ctl_lane = {1'b0, reg_wdata_i[2:0]} + (pg ? HALF[3:0] : 4'h0);

  // Counter view selected through the lane and type select register, paged per link
  wire [3:0] cnt_lane = {1'b0, cntsel_r[`JLEM_LANESEL_LO +: 3]} + (pg ? HALF[3:0] : 4'h0);
  wire [7:0] cnt_view = (cntsel_r[1:0] == `JLEM_CNT_NONE) ? 8'h00 :
                        cnt_r[3*cnt_lane + cntsel_r[1:0]];

  genvar g, t;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      wire [7:0] calc = reg_ctl_mode(g);
      // Compared live so a failure is flagged in the same cycle as the end of alignment
      assign chk_now[g] = (calc == rx_chksum_i[8*g +: 8]);
      always @(posedge clk_i) begin
        if (reset_i) begin
          chk_ok_r[g] <= 1'b0;
          disp_run_r[g] <= 3'h0;
        end else begin
          if (ilas_done_i[g])
            chk_ok_r[g] <= chk_now[g];
          if (reinit_o)
            disp_run_r[g] <= 3'h0;
          else if (disp_err_i[g] && disp_run_r[g] != `JLEM_DISP_REINIT)
            disp_run_r[g] <= disp_run_r[g] + 3'h1;
        end
      end
      for (t = 0; t < 3; t = t + 1) begin : g_type
        wire ev = (t == 0) ? disp_err_i[g] : (t == 1) ? not_in_table_error_i[g] : ctrl_err_i[g];
        wire ctl = wr_hit(`JLEM_A_ERRCTL_DIS + t) && (ctl_lane == g);
        wire unmasked = gate && mask_r[`JLEM_ERR_LO + 2 - t];
        always @(posedge clk_i) begin
          if (reset_i) begin
            cnt_r[3*g+t] <= 8'h00;
            irq_err_r[t][g] <= 1'b0;
            dis_cnt_r[t][g] <= 1'b0;
          end else begin
            if (ctl) dis_cnt_r[t][g] <= reg_wdata_i[`JLEM_DISCNT_BIT];
            if (reinit_o || (ctl && reg_wdata_i[`JLEM_RSTCNT_BIT]))
              cnt_r[3*g+t] <= 8'h00;
            else if (ev && !dis_cnt_r[t][g] &&
                     (unmasked ? cnt_r[3*g+t] != 8'hFF : cnt_r[3*g+t] < limit_r))
              cnt_r[3*g+t] <= cnt_r[3*g+t] + 8'h01;
            if (irqen_r[`JLEM_ERR_LO + 2 - t] && cnt_r[3*g+t] >= limit_r)
              irq_err_r[t][g] <= 1'b1;
            else if (ctl && reg_wdata_i[`JLEM_CLRIRQ_BIT])
              irq_err_r[t][g] <= 1'b0;
          end
        end
      end
    end
    for (g = 0; g < 2; g = g + 1) begin : g_link
      for (t = 0; t < 3; t = t + 1) begin : g_tl
        wire ev = (t == 0) ? |disp_err_i[g*HALF +: HALF] :
                  (t == 1) ? |not_in_table_error_i[g*HALF +: HALF] : |ctrl_err_i[g*HALF +: HALF];
        reg hit;
        integer k;
        always @* begin
          hit = 1'b0;
          for (k = 0; k < HALF; k = k + 1)
            if (cnt_r[3*(g*HALF+k)+t] >= limit_r) hit = 1'b1;
        end
        assign err_any[g][t] = ev;
        assign at_lim[g][t] = hit && gate && mask_r[`JLEM_ERR_LO + 2 - t];
      end
      reg d4;
      integer j;
      always @* begin
        d4 = 1'b0;
        for (j = 0; j < HALF; j = j + 1)
          if (disp_run_r[g*HALF+j] == `JLEM_DISP_REINIT) d4 = 1'b1;
      end
      assign disp4[g] = d4;
      wire reinit_req = disp4[g] || |at_lim[g];
      always @(posedge clk_i) begin
        if (reset_i) begin
          state_r[g] <= ST_IDLE;
          tmr_r[g] <= 8'h00;
          sync_request_out_n_o[g] <= 1'b1;
        end else begin
          case (state_r[g])
            ST_IDLE: begin
              if (reinit_req) begin
                state_r[g] <= ST_HOLD;
                tmr_r[g] <= hold_len;
                sync_request_out_n_o[g] <= 1'b0;
              end else if (|err_any[g]) begin
                state_r[g] <= ST_PULSE;
                sync_request_out_n_o[g] <= 1'b0;
                tmr_r[g] <= (pulse_cfg_r[`JLEM_PULSE_LO +: 2] == `JLEM_PULSE_TWO) ? 8'h02 : 8'h01;
              end
            end
            ST_PULSE: begin
              if (reinit_req) begin
                state_r[g] <= ST_HOLD;
                tmr_r[g] <= hold_len;
              end else if ((pulse_cfg_r[`JLEM_PULSE_LO +: 2] == `JLEM_PULSE_HALF && pclk_half_i) ||
                           (pulse_cfg_r[`JLEM_PULSE_LO +: 2] != `JLEM_PULSE_HALF && pclk_tick_i)) begin
                if (tmr_r[g] <= 8'h01 || pulse_cfg_r[`JLEM_PULSE_LO +: 2] == `JLEM_PULSE_HALF) begin
                  state_r[g] <= ST_IDLE;
                  sync_request_out_n_o[g] <= 1'b1;
                end else begin
                  tmr_r[g] <= tmr_r[g] - 8'h01;
                end
              end
            end
            ST_HOLD: begin
              if (tmr_r[g] <= 8'h01) begin
                state_r[g] <= ST_IDLE;
                sync_request_out_n_o[g] <= 1'b1;
              end else begin
                tmr_r[g] <= tmr_r[g] - 8'h01;
              end
            end
            default: begin
              state_r[g] <= ST_IDLE;
              sync_request_out_n_o[g] <= 1'b1;
            end
          endcase
        end
      end
    end
  endgenerate

  // Mode 1 sums received registers plus lane id, mode 0 the individual fields
  function [7:0] reg_ctl_mode;
    input integer ln;
    begin
      reg_ctl_mode = page_r[`JLEM_CHKMODE_BIT] ?
                     rx_reg_sum_i[8*ln +: 8] + rx_lane_id_i[8*ln +: 8] :
                     rx_field_sum_i[8*ln +: 8];
    end
  endfunction

  wire [LANES-1:0] chk_fail = ilas_done_i & ~chk_now;

  always @(posedge clk_i) begin
    if (reset_i) begin
      page_r <= `JLEM_ZERO8;
      pulse_cfg_r <= `JLEM_ZERO8;
      cntsel_r <= `JLEM_ZERO8;
      thr_r <= `JLEM_ZERO8;
      irqen_r <= `JLEM_ZERO8;
      mask_r <= `JLEM_MASK_RST;
      limit_r <= `JLEM_LIMIT_RST;
      irq_st_r <= 4'h0;
      mm_st_r <= 1'b0;
      reinit_o <= 1'b0;
      cgs_d_r <= {LANES{1'b0}};
      fs_d_r <= {LANES{1'b0}};
      il_d_r <= {LANES{1'b0}};
    end else begin
      reinit_o <= |disp4 || |at_lim[0] || |at_lim[1];
      cgs_d_r <= cgs_ok_i;
      fs_d_r <= fsync_ok_i;
      il_d_r <= ilas_ok_i;
      if (wr_hit(`JLEM_A_PAGE)) page_r <= reg_wdata_i;
      if (wr_hit(`JLEM_A_PULSE)) pulse_cfg_r <= reg_wdata_i;
      if (wr_hit(`JLEM_A_CNTSEL)) cntsel_r <= reg_wdata_i;
      if (wr_hit(`JLEM_A_THRCTL)) thr_r <= reg_wdata_i;
      if (wr_hit(`JLEM_A_IRQ)) irqen_r <= reg_wdata_i;
      if (wr_hit(`JLEM_A_MASK)) mask_r <= {reg_wdata_i[7:5], 1'b0, reg_wdata_i[3:0]};
      if (wr_hit(`JLEM_A_LIMIT)) limit_r <= reg_wdata_i;
      // CGS, frame sync and ILAS failures are falling status levels, checksum failure a mismatch at ilas_done_i; a set in the clear cycle wins
      irq_st_r[0] <= (irqen_r[0] && |(cgs_d_r & ~cgs_ok_i)) ? 1'b1 :
                     (wr_hit(`JLEM_A_CGS) && reg_wdata_i[`JLEM_CGS_CLR_BIT]) ? 1'b0 : irq_st_r[0];
      irq_st_r[1] <= (irqen_r[1] && |(fs_d_r & ~fsync_ok_i)) ? 1'b1 :
                     (wr_hit(`JLEM_A_FSYNC) && reg_wdata_i[0]) ? 1'b0 : irq_st_r[1];
      irq_st_r[2] <= (irqen_r[2] && |chk_fail) ? 1'b1 :
                     (wr_hit(`JLEM_A_CHKSUM) && reg_wdata_i[0]) ? 1'b0 : irq_st_r[2];
      irq_st_r[3] <= (irqen_r[3] && |(il_d_r & ~ilas_ok_i)) ? 1'b1 :
                     (wr_hit(`JLEM_A_ILAS) && reg_wdata_i[0]) ? 1'b0 : irq_st_r[3];
      mm_st_r <= (mask_r[`JLEM_MM_EN_BIT] && cfg_mismatch_i[pg]) ? 1'b1 :
                 (wr_hit(`JLEM_A_MASK) && reg_wdata_i[`JLEM_MM_ST_BIT]) ? 1'b0 : mm_st_r;
    end
  end

  assign irq_n_o = ~(|irq_st_r || mm_st_r || |irq_err_r[0] || |irq_err_r[1] || |irq_err_r[2]);

  // Read data is registered; unmapped addresses return zero
  always @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= `JLEM_ZERO8;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `JLEM_A_PAGE:   reg_rdata_o <= page_r;
        `JLEM_A_PULSE:  reg_rdata_o <= pulse_cfg_r;
        `JLEM_A_CNTSEL: reg_rdata_o <= cnt_view;
        `JLEM_A_CGS:    reg_rdata_o <= page_sel(cgs_ok_i, pg);
        `JLEM_A_FSYNC:  reg_rdata_o <= page_sel(fsync_ok_i, pg);
        `JLEM_A_CHKSUM: reg_rdata_o <= page_sel(chk_ok_r, pg);
        `JLEM_A_ILAS:   reg_rdata_o <= page_sel(ilas_ok_i, pg);
        `JLEM_A_THRCTL: reg_rdata_o <= thr_r;
        `JLEM_A_IRQ:    reg_rdata_o <= {irqen_r[7] & |irq_err_r[0], irqen_r[6] & |irq_err_r[1],
                                        irqen_r[5] & |irq_err_r[2], 1'b0,
                                        irqen_r[3:0] & irq_st_r};
        `JLEM_A_MASK:   reg_rdata_o <= {mask_r[7:5], mm_st_r, mask_r[3:0]};
        `JLEM_A_LIMIT:  reg_rdata_o <= limit_r;
        default:        reg_rdata_o <= `JLEM_ZERO8;
      endcase
    end
  end

endmodule // jlem_monitor
`default_nettype wire

// ==== pkg/jlem_consts.vh ====
// Register map, field positions, reset values and timing counts of the link error monitor
// Included by the monitor logic; definitions only
`ifndef JLEM_CONSTS_VH
`define JLEM_CONSTS_VH

`define JLEM_ADDR_W          12
`define JLEM_A_PAGE          12'h300
`define JLEM_A_PULSE         12'h312
`define JLEM_A_CNTSEL        12'h46B
`define JLEM_A_ERRCTL_DIS    12'h46D
`define JLEM_A_ERRCTL_NIT    12'h46E
`define JLEM_A_ERRCTL_UCC    12'h46F
`define JLEM_A_CGS           12'h470
`define JLEM_A_FSYNC         12'h471
`define JLEM_A_CHKSUM        12'h472
`define JLEM_A_ILAS          12'h473
`define JLEM_A_THRCTL        12'h477
`define JLEM_A_IRQ           12'h47A
`define JLEM_A_MASK          12'h47B
`define JLEM_A_LIMIT         12'h47C

`define JLEM_PAGE_BIT        2
`define JLEM_CHKMODE_BIT     6
`define JLEM_PULSE_LO        4
`define JLEM_GATE_BIT        3
`define JLEM_MM_EN_BIT       3
`define JLEM_MM_ST_BIT       4
`define JLEM_CGS_CLR_BIT     7
`define JLEM_CLRIRQ_BIT      7
`define JLEM_DISCNT_BIT      6
`define JLEM_RSTCNT_BIT      5
`define JLEM_ERR_LO          5
`define JLEM_LANESEL_LO      4
`define JLEM_CNT_NONE        2'h3

`define JLEM_MASK_RST        8'h08
`define JLEM_LIMIT_RST       8'hFF
`define JLEM_ZERO8           8'h00

`define JLEM_PULSE_HALF      2'h0
`define JLEM_PULSE_ONE       2'h1
`define JLEM_PULSE_TWO       2'h2

`define JLEM_DISP_REINIT     3'h4
`define JLEM_RESYNC_FRAMES   8'h05
`define JLEM_RESYNC_OCTETS   8'h09

`endif

// ==== test/jlem_monitor_asserts.sv ====
// Port-level assertions for the link error monitor
// Bound into every jlem_monitor; lanes 0-3 belong to link 0, lanes 4-7 to link 1
`timescale 1ns/1ns
`default_nettype none
`include "jlem_consts.vh"
module jlem_mon_chk #(
  parameter LANES        = 8,
  parameter FRAME_OCTETS = 8'h02
) (
  input wire logic                    clk_i,
  input wire logic                    reset_i,
  input wire logic [LANES-1:0]        disp_err_i,
  input wire logic [LANES-1:0]        not_in_table_error_i,
  input wire logic [LANES-1:0]        ctrl_err_i,
  input wire logic                    reg_wr_i,
  input wire logic                    reg_rd_i,
  input wire logic [`JLEM_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0]              reg_wdata_i,
  input wire logic [7:0]              reg_rdata_o,
  input wire logic                    link_page_o,
  input wire logic                    reinit_o,
  input wire logic                    irq_n_o,
  input wire logic [1:0]              sync_request_out_n_o
);
  wire [LANES-1:0] any_err = disp_err_i | not_in_table_error_i | ctrl_err_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_err_pulse_l0: assert property (|any_err[3:0] |=> !sync_request_out_n_o[0])
    else $error("link 0 error gave no sync pulse");
  a_err_pulse_l1: assert property (|any_err[7:4] |=> !sync_request_out_n_o[1])
    else $error("link 1 error gave no sync pulse");
  a_pulse_ends: assert property ($fell(sync_request_out_n_o[0]) |-> ##[1:400] sync_request_out_n_o[0])
    else $error("link 0 sync request never released");
  a_reset_idle: assert property ($fell(reset_i) |-> sync_request_out_n_o == 2'b11 && irq_n_o && !reinit_o)
    else $error("outputs not idle after reset");
  a_irq_sticky: assert property (!irq_n_o && !reg_wr_i |=> !irq_n_o)
    else $error("interrupt dropped without a register write");
  a_reinit_hold: assert property ($rose(reinit_o) |-> ##[0:2] (sync_request_out_n_o != 2'b11) [*8])
    else $error("reinit sync request too short");
  a_page_set: assert property (reg_wr_i && reg_addr_i == `JLEM_A_PAGE && reg_wdata_i[2] |=> link_page_o)
    else $error("page bit not set");
  a_page_clr: assert property (reg_wr_i && reg_addr_i == `JLEM_A_PAGE && !reg_wdata_i[2] |=> !link_page_o)
    else $error("page bit not cleared");
  a_limit_rdback: assert property (reg_wr_i && reg_addr_i == `JLEM_A_LIMIT ##1 !reg_wr_i ##1 reg_rd_i && reg_addr_i == `JLEM_A_LIMIT |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("limit readback differs from written value");
endmodule // jlem_mon_chk
bind jlem_monitor jlem_mon_chk #(.LANES(LANES), .FRAME_OCTETS(FRAME_OCTETS)) i_jlem_mon_chk (
  .clk_i, .reset_i, .disp_err_i, .not_in_table_error_i, .ctrl_err_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .link_page_o, .reinit_o, .irq_n_o,
  .sync_request_out_n_o);
`default_nettype wire

// ==== test/jlem_tx_model.sv ====
// Transmitter-side model: restarts lane bring-up whenever its link's sync request is low
// Counts clk_i cycles as characters; lanes 0-3 follow link 0, lanes 4-7 follow link 1
`timescale 1ns/1ns
`default_nettype none
module jlem_tx_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [1:0] sync_n_i,
  output var  logic [7:0] cgs_o,
  output var  logic [7:0] fsync_o,
  output var  logic [7:0] ilas_o,
  output var  logic [7:0] done_o
);
  logic [7:0] cnt_r [2];
  always @(posedge clk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (reset_i || !sync_n_i[k]) begin
        cnt_r[k] <= 8'h00;
      end else begin
        // Wraps past the ILAS point so the status levels stay high and done_o pulses every 16 cycles
        cnt_r[k] <= (cnt_r[k] == 8'hFF) ? 8'h10 : cnt_r[k] + 8'h01;
      end
    end
  end
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      cgs_o[4*k+:4]   = {4{cnt_r[k] >= 8'h04}};
      fsync_o[4*k+:4] = {4{cnt_r[k] >= 8'h08}};
      ilas_o[4*k+:4]  = {4{cnt_r[k] >= 8'h0C}};
      done_o[4*k+:4]  = {4{cnt_r[k] >= 8'h0C && cnt_r[k][3:0] == 4'hC}};
    end
  end
endmodule // jlem_tx_model
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the link error monitor against a transmitter model
// Assumes a 50 MHz clk_i, inputs driven on the falling edge, lanes 0-3 on link 0
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [7:0] FO = 8'h02;
  logic            clk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic            pclk_tick_i = 1'b0, pclk_half_i = 1'b0, frame_tick_i = 1'b0;
  logic            link_page_o, reinit_o, irq_n_o;
  logic [7:0]      disp_err_i = 8'h00, nit_err = 8'h00, ctrl_err_i = 8'h00, reg_wdata_i = 8'h00;
  logic [7:0]      cgs, fsy, ila, done, reg_rdata_o, v;
  logic [7:0][7:0] fs, rs, id, ck;
  logic [1:0]      mm = 2'b00, sync_n;
  logic [11:0]     reg_addr_i = 12'h000;
  logic [31:0]     seed = 32'h0000_7743;
  int              bad_count = 0, check_count = 0, cyc = 0, n;
  int              lo[3] = '{1, 1, 4}, hi[3] = '{3, 5, 9};
  initial forever #10 clk_i = ~clk_i;
  jlem_monitor #(.LANES(8), .FRAME_OCTETS(FO)) i_jlem_monitor (.clk_i, .reset_i, .pclk_tick_i,
    .pclk_half_i, .frame_tick_i, .disp_err_i, .not_in_table_error_i(nit_err), .ctrl_err_i,
    .cgs_ok_i(cgs), .fsync_ok_i(fsy), .ilas_ok_i(ila), .ilas_done_i(done), .rx_field_sum_i(fs),
    .rx_reg_sum_i(rs), .rx_lane_id_i(id), .rx_chksum_i(ck), .cfg_mismatch_i(mm), .reg_wr_i,
    .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .link_page_o, .reinit_o, .irq_n_o,
    .sync_request_out_n_o(sync_n));
  jlem_tx_model i_jlem_tx_model (.clk_i, .reset_i, .sync_n_i(sync_n), .cgs_o(cgs),
    .fsync_o(fsy), .ilas_o(ila), .done_o(done));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected good-checksum bits for mode m[1] and page m[0]
  function automatic logic [7:0] good(input int m);
    int l;
    good = 8'h00;
    for (int g = 0; g < 4; g++) begin
      l = 4 * m[0] + g;
      good[g] = m[1] ? (8'(rs[l] + id[l]) == ck[l]) : (fs[l] == ck[l]);
    end
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    {reg_rd_i, reg_addr_i} = {1'b1, a};
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    v = reg_rdata_o;
    if (m != 8'h00) chk(v & m, e);
    @(negedge clk_i);
  endtask
  // One-cycle error strobe, then count cycles until that link's sync request releases
  task automatic hit(ref logic [7:0] e, input int ln, output int k);
    e[ln] = 1'b1;
    @(negedge clk_i);
    e[ln] = 1'b0;
    k = 0;
    while (sync_n[ln / 4] !== 1'b1 && k < 500) begin
      @(negedge clk_i);
      k++;
    end
    @(negedge clk_i);
  endtask
  always @(negedge clk_i) begin
    cyc <= cyc + 1;
    pclk_tick_i <= (cyc % 4 == 0);
    pclk_half_i <= (cyc % 2 == 0);
    frame_tick_i <= (cyc % 2 == 0);
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    for (int g = 0; g < 8; g++) begin
      seed = lfsr(seed);
      {ck[g], fs[g], rs[g], id[g]} = {seed[7:0], seed[7:0], seed[7:0] - 8'(g), 8'(g)};
    end
    repeat (8) @(negedge clk_i);
    reset_i = 1'b0;
    rd(12'h47C, 8'hFF, 8'hFF);
    rd(12'h47B, 8'hFF, 8'h08);
    rd(12'h123, 8'hFF, 8'h00);
    seed = lfsr(seed);
    wr(12'h47C, seed[7:0]);
    rd(12'h47C, 8'hFF, seed[7:0]);
    wr(12'h47C, 8'hFF);
    for (int s = 0; s < 3; s++) begin
      wr(12'h312, 8'(s << 4));
      for (int j = 0; j < 2; j++) begin
        seed = lfsr(seed);
        if (j == 0) hit(nit_err, int'(seed[1:0]), n);
        else hit(ctrl_err_i, 4 + int'(seed[1:0]), n);
        chk(8'(n >= lo[s] && n <= hi[s]), 8'h01);
      end
    end
    wr(12'h47A, 8'h0F);
    for (int k = 1; k <= 7; k++) begin
      hit(disp_err_i, 2, n);
      if (k == 4) chk(8'(n >= 5 * FO + 9 && n <= 5 * FO + 20), 8'h01);
      else chk({7'h00, reinit_o}, 8'h00);
    end
    chk({7'h00, irq_n_o}, 8'h00);
    repeat (40) @(negedge clk_i);
    rd(12'h47A, 8'h00, 8'h00);
    chk(8'($countones(v[3:0])), 8'h03);
    wr(12'h470, 8'h80);
    for (int a = 1; a < 4; a++) wr(12'h470 + 12'(a), 8'h01);
    chk({7'h00, irq_n_o}, 8'h01);
    mm = 2'b01;
    repeat (2) @(negedge clk_i);
    chk({7'h00, irq_n_o}, 8'h00);
    mm = 2'b00;
    rd(12'h47B, 8'h18, 8'h18);
    wr(12'h47B, 8'h18);
    rd(12'h47B, 8'h18, 8'h08);
    chk({7'h00, irq_n_o}, 8'h01);
    {fs[1], fs[6], id[2], id[5]} = {fs[1] ^ 8'h01, fs[6] ^ 8'h01, id[2] + 8'h01, id[5] + 8'h01};
    for (int m = 0; m < 4; m++) begin
      wr(12'h300, {1'b0, m[1], 3'h0, m[0], 2'h0});
      repeat (40) @(negedge clk_i);
      for (int a = 0; a < 4; a++) rd(12'h470 + 12'(a), 8'h0F, a == 2 ? good(m) : 8'h0F);
    end
    wr(12'h300, 8'h00);
    wr(12'h47C, 8'h02);
    hit(nit_err, 0, n);
    hit(nit_err, 0, n);
    chk(8'(n <= 9), 8'h01);
    hit(nit_err, 0, n);
    wr(12'h46B, 8'h01);
    rd(12'h46B, 8'hFF, 8'h02);
    wr(12'h46E, 8'hA0);
    wr(12'h47B, 8'h48);
    wr(12'h477, 8'h08);
    wr(12'h47A, 8'h40);
    rd(12'h47A, 8'hE0, 8'h00);
    hit(nit_err, 0, n);
    hit(nit_err, 0, n);
    chk(8'(n >= 10), 8'h01);
    rd(12'h47A, 8'hE0, 8'h40);
    wr(12'h46E, 8'h80);
    rd(12'h47A, 8'hE0, 8'h00);
    close_out();
  end
endmodule // testbench
`default_nettype wire
